//--- rtl/tsc_pkg.sv
package tsc_pkg;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [7:0] OFF_SOURCE = 8'h00;
  localparam logic [7:0] OFF_SPT = 8'h04;
  localparam logic [7:0] OFF_REMAIN = 8'h08;
  localparam logic [7:0] OFF_INTERVAL = 8'h0C;
  localparam logic [7:0] OFF_COMMAND = 8'h10;
  localparam logic [7:0] OFF_STB = 8'h14;
  localparam logic [7:0] OFF_STB_BIT = 8'h18;
  localparam logic [7:0] OFF_BIT_INDEX = 8'h1C;
  localparam logic [7:0] OFF_ESR = 8'h20;
  localparam logic [7:0] OFF_ESR_BIT = 8'h24;
  localparam logic [7:0] OFF_COMM_ERROR_FLAGS = 8'h28;
  localparam logic [7:0] OFF_COMM_ERROR_FLAGS_BIT = 8'h2C;
  localparam logic [7:0] OFF_CHANNEL_STATUS_FLAGS = 8'h30;
  localparam logic [7:0] OFF_CHANNEL_STATUS_FLAGS_BIT = 8'h34;
  localparam logic [7:0] OFF_SRE = 8'h38;
  localparam logic [7:0] OFF_SRE_BIT = 8'h3C;
  localparam logic [7:0] OFF_ESE = 8'h40;
  localparam logic [7:0] OFF_ESE_BIT = 8'h44;
  localparam logic [7:0] OFF_COMM_ERROR_ENABLE_MASK = 8'h48;
  localparam logic [7:0] OFF_COMM_ERROR_ENABLE_MASK_BIT = 8'h4C;
  localparam logic [7:0] OFF_CHANNEL_STATUS_ENABLE_MASK = 8'h50;
  localparam logic [7:0] OFF_CHANNEL_STATUS_ENABLE_MASK_BIT = 8'h54;
  localparam logic [7:0] OFF_PULSE = 8'h58;
  localparam logic [7:0] OFF_BUTTON = 8'h5C;
  localparam logic [7:0] OFF_EXEC_ERR = 8'h60;

  // ****************************************
  // Field codes and limits
  // ****************************************
  localparam logic [1:0] SRC_LOCAL = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL = 2'h1;
  localparam logic [1:0] SRC_REMOTE = 2'h2;
  localparam int CMD_REMOTE_TRIGGER_FLAG_BIT_BIT = 0;
  localparam int CMD_CLEAR_STATUS_BIT = 1;
  localparam int CMD_RESET_BIT = 2;
  localparam int STB_TRIGGER_FLAG_BIT_BIT = 0;
  localparam int STB_CES_BIT = 2;
  localparam int STB_CHS_BIT = 3;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_ILLEGAL_VALUE = 8'h01;
  localparam logic [7:0] ERR_WRONG_MODE = 8'h12;
  localparam logic [31:0] SPT_MAX = 32'h0000FFFF;
  localparam logic [31:0] INTERVAL_STEP_MS = 32'h0000000A;
  localparam logic [31:0] INTERVAL_MAX_MS = 32'h0009FFF6;
  localparam logic [19:0] INTERVAL_RESET_MS = 20'h003E8;
  localparam logic [15:0] SPT_RESET = 16'h0001;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int unsigned MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int PULSE_MIN_NS = 1000;
  localparam logic [7:0] PULSE_CYCLES = 8'((PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic {ST_IDLE, ST_WAIT} tsc_seq_e;

  typedef struct packed {
    logic [7:0] std_event;
    logic [7:0] comm_error;
    logic [7:0] channel;
  } tsc_event_s;

endpackage

//--- rtl/tsc_top.sv
// What this block does
// [RL1] One sample strobe serves every channel together
// [RL2] Trigger source: local 0, external 1, remote 2
// [RL3] Samples per trigger settable, at most 65535
// [RL4] Remaining count write only ever decreases it
// [RL5] Zero remaining ends ensemble; count always readable
// [RL6] Interval in ms, multiple of ten, bounded
// [RL7] Triggered samples spaced by programmed interval
// [RL8] Host selects remote source before remote trigger
// [RL9] Clear-status wipes event, comm, channel flags
// [RL10] Full status byte read releases request line
// [RL11] Indexed status byte read leaves line alone
// [RL12] Any status byte read clears trigger flag
// [RL13] Event register read clears returned bits
// [RL14] Comm error read clears returned bits
// [RL15] Channel status read clears returned bits
// [RL16] Four enable masks, whole or indexed access
// [RL17] Pulse mode: line low 1 us, or less if a full status read comes first
// [RL18] Latch mode: low until full status read
// [RL19] Last button 1 to 4, zero once read
// [RL20] Wrong-mode error code 18 raised
// [RL21] Reset command: 1000 ms, local, one trigger
// [RL22] Request when enabled status bit is set
// [RL23] Bad count or interval rejected, unchanged
`timescale 1ns/100ps
module tsc_top #(
  parameter int unsigned MS_TICK_CYCLES = tsc_pkg::MS_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic local_trigger,
  input wire logic external_trigger,
  input wire logic button_valid,
  input wire logic [1:0] button_id,
  input wire tsc_pkg::tsc_event_s events,
  output logic sample_strobe,
  output logic busy,
  output logic status_n
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] onehot(input logic [2:0] idx);
    onehot = 8'h01 << idx;
  endfunction

  function automatic logic [7:0] flag_upd(input logic [7:0] cur, input logic [7:0] set, input logic [7:0] clr);
    flag_upd = (cur & ~clr) | set;
  endfunction

  function automatic logic [7:0] mask_wr(input logic [7:0] cur, input logic whole, input logic one,
                                         input logic [2:0] idx, input logic [31:0] d);
    mask_wr = whole ? d[7:0] : (one ? ((cur & ~onehot(idx)) | (d[0] ? onehot(idx) : 8'h00)) : cur);
  endfunction

  function automatic logic [31:0] bit_rd(input logic [7:0] v, input logic [2:0] idx);
    bit_rd = {31'h0, v[idx]};
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [1:0] src_r;
  logic [15:0] spt_r;
  logic [15:0] rem_r;
  logic [15:0] rem_nxt;
  logic [19:0] interval_r;
  logic [19:0] ms_r;
  logic [19:0] ms_nxt;
  logic [31:0] tick_r;
  logic [31:0] tick_nxt;
  tsc_pkg::tsc_seq_e state_r;
  tsc_pkg::tsc_seq_e state_nxt;
  logic strobe_nxt;
  logic [2:0] idx_r;
  logic [7:0] esr_r;
  logic [7:0] comm_error_flags_r;
  logic [7:0] channel_status_flags_r;
  logic [7:0] sre_r;
  logic [7:0] ese_r;
  logic [7:0] comm_error_enable_mask_r;
  logic [7:0] channel_status_enable_mask_r;
  logic trigger_flag_bit_flag_r;
  logic pulse_sel_r;
  logic latched_r;
  logic [7:0] pulse_cnt_r;
  logic srq_prev_r;
  logic [2:0] button_r;
  logic [7:0] err_r;
  logic [7:0] clr_mask_r;

  // ****************************************
  // APB decode
  // ****************************************
  // One wait-free access phase: pready rises the cycle after setup
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire a_src = paddr == tsc_pkg::OFF_SOURCE;
  wire a_spt = paddr == tsc_pkg::OFF_SPT;
  wire a_rem = paddr == tsc_pkg::OFF_REMAIN;
  wire a_int = paddr == tsc_pkg::OFF_INTERVAL;
  wire a_cmd = paddr == tsc_pkg::OFF_COMMAND;
  wire a_stb = paddr == tsc_pkg::OFF_STB;
  wire a_stb_bit = paddr == tsc_pkg::OFF_STB_BIT;
  wire a_idx = paddr == tsc_pkg::OFF_BIT_INDEX;
  wire a_esr = paddr == tsc_pkg::OFF_ESR;
  wire a_esr_bit = paddr == tsc_pkg::OFF_ESR_BIT;
  wire a_comm_error_flags = paddr == tsc_pkg::OFF_COMM_ERROR_FLAGS;
  wire a_comm_error_flags_bit = paddr == tsc_pkg::OFF_COMM_ERROR_FLAGS_BIT;
  wire a_channel_status_flags = paddr == tsc_pkg::OFF_CHANNEL_STATUS_FLAGS;
  wire a_channel_status_flags_bit = paddr == tsc_pkg::OFF_CHANNEL_STATUS_FLAGS_BIT;
  wire a_sre = paddr == tsc_pkg::OFF_SRE;
  wire a_sre_bit = paddr == tsc_pkg::OFF_SRE_BIT;
  wire a_ese = paddr == tsc_pkg::OFF_ESE;
  wire a_ese_bit = paddr == tsc_pkg::OFF_ESE_BIT;
  wire a_comm_error_enable_mask = paddr == tsc_pkg::OFF_COMM_ERROR_ENABLE_MASK;
  wire a_comm_error_enable_mask_bit = paddr == tsc_pkg::OFF_COMM_ERROR_ENABLE_MASK_BIT;
  wire a_channel_status_enable_mask = paddr == tsc_pkg::OFF_CHANNEL_STATUS_ENABLE_MASK;
  wire a_channel_status_enable_mask_bit = paddr == tsc_pkg::OFF_CHANNEL_STATUS_ENABLE_MASK_BIT;
  wire a_pulse = paddr == tsc_pkg::OFF_PULSE;
  wire a_btn = paddr == tsc_pkg::OFF_BUTTON;
  wire a_err = paddr == tsc_pkg::OFF_EXEC_ERR;
  wire hit = |{a_src, a_spt, a_rem, a_int, a_cmd, a_stb, a_stb_bit, a_idx, a_esr, a_esr_bit, a_comm_error_flags,
               a_comm_error_flags_bit, a_channel_status_flags, a_channel_status_flags_bit, a_sre, a_sre_bit, a_ese, a_ese_bit, a_comm_error_enable_mask, a_comm_error_enable_mask_bit,
               a_channel_status_enable_mask, a_channel_status_enable_mask_bit, a_pulse, a_btn, a_err};

  // ****************************************
  // Status byte and service request
  // ****************************************
  wire req_pending = latched_r | (pulse_cnt_r != 8'h00);
  wire [7:0] stb_core = (8'h01 << tsc_pkg::STB_TRIGGER_FLAG_BIT_BIT) & {8{trigger_flag_bit_flag_r}}
                      | (8'h01 << tsc_pkg::STB_CES_BIT) & {8{|(comm_error_flags_r & comm_error_enable_mask_r)}}
                      | (8'h01 << tsc_pkg::STB_CHS_BIT) & {8{|(channel_status_flags_r & channel_status_enable_mask_r)}}
                      | (8'h01 << tsc_pkg::STB_ESB_BIT) & {8{|(esr_r & ese_r)}};
  wire [7:0] stb_val = stb_core | ((8'h01 << tsc_pkg::STB_RQS_BIT) & {8{req_pending}});
  wire srq_cond = |(stb_core & sre_r); // RL22
  wire srq_rise = srq_cond & ~srq_prev_r;
  wire stb_full_rd = rd & a_stb;
  wire stb_any_rd = rd & (a_stb | a_stb_bit);
  // A new request outranks a release in the same cycle
  wire latched_nxt = (srq_rise & ~pulse_sel_r) | (latched_r & ~stb_full_rd & ~pulse_sel_r); // RL18 RL10
  wire [7:0] pulse_cnt_nxt = (srq_rise & pulse_sel_r) ? tsc_pkg::PULSE_CYCLES :  // RL17
                             (stb_full_rd || pulse_cnt_r == 8'h00) ? 8'h00 : pulse_cnt_r - 8'h01; // RL10
  wire status_n_nxt = ~(latched_nxt | (pulse_cnt_nxt != 8'h00));

  // ****************************************
  // Read mux
  // ****************************************
  wire [31:0] rd_val =
    a_src ? {30'h0, src_r} : // RL2
    a_spt ? {16'h0, spt_r} : // RL3
    a_rem ? {16'h0, rem_r} : // RL5
    a_int ? {12'h0, interval_r} :
    a_stb ? {24'h0, stb_val} :
    a_stb_bit ? bit_rd(stb_val, idx_r) : // RL11
    a_idx ? {29'h0, idx_r} :
    a_esr ? {24'h0, esr_r} :
    a_esr_bit ? bit_rd(esr_r, idx_r) :
    a_comm_error_flags ? {24'h0, comm_error_flags_r} :
    a_comm_error_flags_bit ? bit_rd(comm_error_flags_r, idx_r) :
    a_channel_status_flags ? {24'h0, channel_status_flags_r} :
    a_channel_status_flags_bit ? bit_rd(channel_status_flags_r, idx_r) :
    a_sre ? {24'h0, sre_r} :
    a_sre_bit ? bit_rd(sre_r, idx_r) : // RL16
    a_ese ? {24'h0, ese_r} :
    a_ese_bit ? bit_rd(ese_r, idx_r) :
    a_comm_error_enable_mask ? {24'h0, comm_error_enable_mask_r} :
    a_comm_error_enable_mask_bit ? bit_rd(comm_error_enable_mask_r, idx_r) :
    a_channel_status_enable_mask ? {24'h0, channel_status_enable_mask_r} :
    a_channel_status_enable_mask_bit ? bit_rd(channel_status_enable_mask_r, idx_r) :
    a_pulse ? {31'h0, pulse_sel_r} :
    a_btn ? {29'h0, button_r} : // RL19
    a_err ? {24'h0, err_r} : 32'h0;

  // Snapshot of bits handed out, so late-arriving flags survive the clear
  wire [7:0] flag_sel = (a_esr | a_esr_bit) ? esr_r : ((a_comm_error_flags | a_comm_error_flags_bit) ? comm_error_flags_r : channel_status_flags_r);
  wire is_bit = a_esr_bit | a_comm_error_flags_bit | a_channel_status_flags_bit;
  wire [7:0] clr_mask_nxt = is_bit ? (flag_sel & onehot(idx_r)) : flag_sel;
  wire [7:0] esr_clr = (rd & (a_esr | a_esr_bit)) ? clr_mask_r : 8'h00; // RL13
  wire [7:0] comm_error_flags_clr = (rd & (a_comm_error_flags | a_comm_error_flags_bit)) ? clr_mask_r : 8'h00; // RL14
  wire [7:0] channel_status_flags_clr = (rd & (a_channel_status_flags | a_channel_status_flags_bit)) ? clr_mask_r : 8'h00; // RL15

  // ****************************************
  // Commands and settings
  // ****************************************
  wire remote_cmd = wr & a_cmd & pwdata[tsc_pkg::CMD_REMOTE_TRIGGER_FLAG_BIT_BIT];
  wire clear_cmd = wr & a_cmd & pwdata[tsc_pkg::CMD_CLEAR_STATUS_BIT];
  wire reset_cmd = wr & a_cmd & pwdata[tsc_pkg::CMD_RESET_BIT];
  wire [7:0] all_clr = clear_cmd ? 8'hFF : 8'h00; // RL9
  wire src_bad = wr & a_src & (pwdata > {30'h0, tsc_pkg::SRC_REMOTE});
  wire src_busy = wr & a_src & busy & ~src_bad;
  wire src_ok = wr & a_src & ~busy & ~src_bad; // RL2
  wire spt_bad = wr & a_spt & (pwdata > tsc_pkg::SPT_MAX); // RL23
  wire int_bad = wr & a_int & ((pwdata % tsc_pkg::INTERVAL_STEP_MS != 32'h0) |
                               (pwdata > tsc_pkg::INTERVAL_MAX_MS)); // RL6 RL23
  wire wrong_mode = (remote_cmd & (src_r != tsc_pkg::SRC_REMOTE)) | src_busy; // RL20
  wire [7:0] err_nxt = wrong_mode ? tsc_pkg::ERR_WRONG_MODE :
                       (src_bad | spt_bad | int_bad) ? tsc_pkg::ERR_ILLEGAL_VALUE :
                       (rd & a_err) ? tsc_pkg::ERR_NONE : err_r;
  wire [1:0] src_nxt = reset_cmd ? tsc_pkg::SRC_LOCAL : (src_ok ? pwdata[1:0] : src_r); // RL21
  wire [19:0] interval_nxt = reset_cmd ? tsc_pkg::INTERVAL_RESET_MS :
                             ((wr & a_int & ~int_bad) ? pwdata[19:0] : interval_r); // RL21 RL6
  wire [15:0] spt_nxt = (wr & a_spt & ~spt_bad) ? pwdata[15:0] : spt_r; // RL3
  wire [2:0] button_nxt = button_valid ? {1'b0, button_id} + 3'h1 : ((rd & a_btn) ? 3'h0 : button_r); // RL19

  // ****************************************
  // Trigger sequencer
  // ****************************************
  // Triggers that land mid-ensemble are dropped; only reset restarts it
  wire start = reset_cmd | (~busy & (((src_r == tsc_pkg::SRC_LOCAL) & local_trigger) |
                                     ((src_r == tsc_pkg::SRC_EXTERNAL) & external_trigger) |
                                     ((src_r == tsc_pkg::SRC_REMOTE) & remote_cmd))); // RL8 RL21
  wire start_ok = start & (spt_r != 16'h0000);
  wire rem_shrink = wr & a_rem & (pwdata < {16'h0, rem_r}); // RL4

  always_comb begin
    state_nxt = state_r;
    rem_nxt = rem_r;
    ms_nxt = ms_r;
    tick_nxt = tick_r;
    strobe_nxt = 1'b0;
    if (start_ok) begin
      strobe_nxt = 1'b1; // RL1
      rem_nxt = spt_r - 16'h0001;
      ms_nxt = 20'h00000;
      tick_nxt = 32'h0;
      state_nxt = (spt_r == 16'h0001) ? tsc_pkg::ST_IDLE : tsc_pkg::ST_WAIT;
    end else begin
      case (state_r)
        tsc_pkg::ST_WAIT: begin
          if (tick_r == MS_TICK_CYCLES - 1) begin
            tick_nxt = 32'h0;
            ms_nxt = ms_r + 20'h00001;
          end else begin
            tick_nxt = tick_r + 32'h1;
          end
          if (ms_r >= interval_r) begin // RL7
            strobe_nxt = 1'b1;
            rem_nxt = rem_r - 16'h0001;
            ms_nxt = 20'h00000;
            tick_nxt = 32'h0;
            if (rem_r == 16'h0001) begin
              state_nxt = tsc_pkg::ST_IDLE;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (rem_shrink) begin
      rem_nxt = pwdata[15:0]; // RL4
      if (pwdata == 32'h0) begin
        state_nxt = tsc_pkg::ST_IDLE; // RL5
        strobe_nxt = 1'b0;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      clr_mask_r <= 8'h00;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= setup ? rd_val : prdata;
      clr_mask_r <= setup ? clr_mask_nxt : clr_mask_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_r <= tsc_pkg::SRC_LOCAL;
      spt_r <= tsc_pkg::SPT_RESET;
      interval_r <= tsc_pkg::INTERVAL_RESET_MS;
      err_r <= tsc_pkg::ERR_NONE;
      button_r <= 3'h0;
      idx_r <= 3'h0;
      pulse_sel_r <= 1'b0;
    end else begin
      src_r <= src_nxt;
      spt_r <= spt_nxt;
      interval_r <= interval_nxt;
      err_r <= err_nxt;
      button_r <= button_nxt;
      idx_r <= (wr & a_idx) ? pwdata[2:0] : idx_r;
      pulse_sel_r <= (wr & a_pulse) ? pwdata[0] : pulse_sel_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= tsc_pkg::ST_IDLE;
      rem_r <= 16'h0000;
      ms_r <= 20'h00000;
      tick_r <= 32'h0;
      sample_strobe <= 1'b0;
      busy <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rem_r <= rem_nxt;
      ms_r <= ms_nxt;
      tick_r <= tick_nxt;
      sample_strobe <= strobe_nxt;
      busy <= state_nxt == tsc_pkg::ST_WAIT;
    end
  end

  // Hardware sets win over every clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esr_r <= 8'h00;
      comm_error_flags_r <= 8'h00;
      channel_status_flags_r <= 8'h00;
      trigger_flag_bit_flag_r <= 1'b0;
    end else begin
      esr_r <= flag_upd(esr_r, events.std_event, esr_clr | all_clr);
      comm_error_flags_r <= flag_upd(comm_error_flags_r, events.comm_error, comm_error_flags_clr | all_clr);
      channel_status_flags_r <= flag_upd(channel_status_flags_r, events.channel, channel_status_flags_clr | all_clr);
      trigger_flag_bit_flag_r <= start_ok | (trigger_flag_bit_flag_r & ~stb_any_rd & ~clear_cmd); // RL12 RL9
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sre_r <= 8'h00;
      ese_r <= 8'h00;
      comm_error_enable_mask_r <= 8'h00;
      channel_status_enable_mask_r <= 8'h00;
      latched_r <= 1'b0;
      pulse_cnt_r <= 8'h00;
      srq_prev_r <= 1'b0;
      status_n <= 1'b1;
    end else begin
      sre_r <= mask_wr(sre_r, wr & a_sre, wr & a_sre_bit, idx_r, pwdata); // RL16
      ese_r <= mask_wr(ese_r, wr & a_ese, wr & a_ese_bit, idx_r, pwdata);
      comm_error_enable_mask_r <= mask_wr(comm_error_enable_mask_r, wr & a_comm_error_enable_mask, wr & a_comm_error_enable_mask_bit, idx_r, pwdata);
      channel_status_enable_mask_r <= mask_wr(channel_status_enable_mask_r, wr & a_channel_status_enable_mask, wr & a_channel_status_enable_mask_bit, idx_r, pwdata);
      latched_r <= latched_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
      srq_prev_r <= srq_cond;
      status_n <= status_n_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  src_legal_a: assert property (@(posedge pclk) disable iff (!presetn) src_r <= tsc_pkg::SRC_REMOTE) // RL2
    else $error("trigger source out of range");
  rem_no_grow_a: assert property (@(posedge pclk) disable iff (!presetn) // RL4
    (wr && a_rem && pwdata >= {16'h0, rem_r} && !start_ok) |=> rem_r <= $past(rem_r))
    else $error("remaining count grew on write");
  rem_zero_end_a: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    (wr && a_rem && pwdata == 32'h0 && rem_r != 16'h0000) |=> (!busy && !sample_strobe && rem_r == 16'h0000))
    else $error("zero remaining did not end ensemble");
  interval_ok_a: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    ({12'h0, interval_r} % tsc_pkg::INTERVAL_STEP_MS == 32'h0) && ({12'h0, interval_r} <= tsc_pkg::INTERVAL_MAX_MS))
    else $error("interval not a legal value");
  stb_release_a: assert property (@(posedge pclk) disable iff (!presetn) // RL10
    (stb_full_rd && !srq_rise) |=> status_n)
    else $error("full status read did not release line");
  stb_bit_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    (rd && a_stb_bit && !pulse_sel_r && !status_n) |=> !status_n)
    else $error("indexed status read released line");
  trigger_flag_bit_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    (stb_any_rd && !start_ok) |=> !trigger_flag_bit_flag_r)
    else $error("trigger flag survived status read");
  esr_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RL13
    (rd && a_esr && events.std_event == 8'h00) |=> (esr_r & $past(clr_mask_r)) == 8'h00)
    else $error("event bits not cleared by read");
  pulse_low_a: assert property (@(posedge pclk) disable iff (!presetn) // RL17
    (pulse_sel_r && srq_rise && !stb_full_rd) |=> !status_n [*8])
    else $error("pulse too short");
  latch_low_a: assert property (@(posedge pclk) disable iff (!presetn) // RL18 RL22
    (!pulse_sel_r && srq_rise) |=> !status_n)
    else $error("request did not pull line low");
  wrong_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    (remote_cmd && src_r != tsc_pkg::SRC_REMOTE) |=> err_r == tsc_pkg::ERR_WRONG_MODE)
    else $error("wrong mode error missing");
  reset_cmd_a: assert property (@(posedge pclk) disable iff (!presetn) // RL21
    (reset_cmd && spt_r != 16'h0000) |=> (src_r == tsc_pkg::SRC_LOCAL &&
                                          interval_r == tsc_pkg::INTERVAL_RESET_MS && sample_strobe))
    else $error("reset command defaults wrong");

endmodule

//--- tb/tsc_host.sv
`timescale 1ns/100ps
// ****************************************
// Host side: APB master
// ****************************************
module tsc_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
  end
  // Request held until pready is sampled high; only the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not look like the old word
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps
// ****************************************
// Bench
// ****************************************
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, e, sample_strobe, busy, status_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic local_trigger = 1'b0;
  logic external_trigger = 1'b0;
  logic button_valid = 1'b0;
  logic [1:0] button_id = 2'h0;
  tsc_pkg::tsc_event_s events = '0;
  int err_count = 0;
  int checked = 0;
  int strobes = 0;
  int cyc = 0;
  int last = 0;
  int gap = 0;

  always #10 pclk = ~pclk;

  tsc_top #(.MS_TICK_CYCLES(5)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .local_trigger, .external_trigger, .button_valid, .button_id, .events, .sample_strobe,
    .busy, .status_n);
  tsc_host i_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

  always @(posedge pclk) begin
    cyc++;
    if (sample_strobe === 1'b1) begin
      strobes++;
      gap = cyc - last;
      last = cyc;
    end
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    checked++;
    if (s !== x) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    i_host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rx(logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] x, string n);
    rx(a);
    chk(n, q, x);
  endtask
  // Extra edge lets the last strobe be counted first
  task automatic idle();
    @(posedge pclk);
    while (busy !== 1'b0) @(posedge pclk);
    @(posedge pclk);
  endtask

  task automatic t_cfg();
    rd(tsc_pkg::OFF_INTERVAL, 32'h3E8, "interval");
    for (int v = 0; v < 4; v++) begin
      wr(tsc_pkg::OFF_SOURCE, 32'(v));
      rd(tsc_pkg::OFF_SOURCE, (v == 3) ? 32'h2 : 32'(v), "source");
    end
    wr(tsc_pkg::OFF_SPT, 32'hFFFF);
    wr(tsc_pkg::OFF_SPT, 32'h10000);
    rd(tsc_pkg::OFF_SPT, 32'hFFFF, "count");
    wr(tsc_pkg::OFF_INTERVAL, 32'h9FFF6);
    wr(tsc_pkg::OFF_INTERVAL, 32'h9FFF7);
    wr(tsc_pkg::OFF_INTERVAL, 32'hA0000);
    rd(tsc_pkg::OFF_INTERVAL, 32'h9FFF6, "interval");
    rd(tsc_pkg::OFF_EXEC_ERR, 32'h1, "exec err");
    rx(8'hFC);
    chk("slverr", e, 1);
  endtask

  // Wrong-source trigger first, then the matching one
  task automatic t_trigger_flag_bit();
    wr(tsc_pkg::OFF_SPT, 32'h3);
    wr(tsc_pkg::OFF_INTERVAL, 32'hA);
    for (int s = 0; s < 2; s++) begin
      wr(tsc_pkg::OFF_SOURCE, 32'(s));
      strobes = 0;
      local_trigger <= (s == 1);
      external_trigger <= (s == 0);
      @(posedge pclk);
      local_trigger <= (s == 0);
      external_trigger <= (s == 1);
      @(posedge pclk);
      local_trigger <= 1'b0;
      external_trigger <= 1'b0;
      idle();
      chk("strobes", strobes, 3);
      chk("gap", gap > 49 && gap < 61, 1);
    end
  endtask

  task automatic t_rem();
    wr(tsc_pkg::OFF_SPT, 32'h5);
    strobes = 0;
    external_trigger <= 1'b1;
    @(posedge pclk);
    external_trigger <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("busy", busy, 1);
    rd(tsc_pkg::OFF_REMAIN, 32'h4, "remain");
    wr(tsc_pkg::OFF_REMAIN, 32'h7);
    rd(tsc_pkg::OFF_REMAIN, 32'h4, "remain");
    wr(tsc_pkg::OFF_REMAIN, 32'h2);
    rd(tsc_pkg::OFF_REMAIN, 32'h2, "remain");
    wr(tsc_pkg::OFF_REMAIN, 32'h0);
    chk("busy", busy, 0);
    idle();
    repeat (100) @(posedge pclk);
    chk("strobes", strobes, 1);
  endtask

  task automatic t_remote();
    wr(tsc_pkg::OFF_SOURCE, 32'h0);
    wr(tsc_pkg::OFF_SPT, 32'h2);
    strobes = 0;
    wr(tsc_pkg::OFF_COMMAND, 32'h1);
    rd(tsc_pkg::OFF_EXEC_ERR, 32'h12, "exec err");
    wr(tsc_pkg::OFF_SOURCE, 32'h2);
    wr(tsc_pkg::OFF_COMMAND, 32'h1);
    wr(tsc_pkg::OFF_SOURCE, 32'h0);
    rd(tsc_pkg::OFF_SOURCE, 32'h2, "source");
    rd(tsc_pkg::OFF_EXEC_ERR, 32'h12, "exec err");
    idle();
    chk("strobes", strobes, 2);
  endtask

  task automatic t_stat();
    int n;
    wr(tsc_pkg::OFF_SPT, 32'h1);
    wr(tsc_pkg::OFF_SRE, 32'h1);
    wr(tsc_pkg::OFF_COMMAND, 32'h1);
    repeat (3) @(posedge pclk);
    chk("status_n", status_n, 0);
    wr(tsc_pkg::OFF_BIT_INDEX, 32'h0);
    rd(tsc_pkg::OFF_STB_BIT, 32'h1, "stb bit");
    chk("status_n", status_n, 0);
    rd(tsc_pkg::OFF_STB_BIT, 32'h0, "stb bit");
    chk("status_n", status_n, 0);
    rx(tsc_pkg::OFF_STB);
    chk("status_n", status_n, 1);
    wr(tsc_pkg::OFF_PULSE, 32'h1);
    wr(tsc_pkg::OFF_COMMAND, 32'h1);
    n = 0;
    while (status_n !== 1'b0 && n++ < 20) @(posedge pclk);
    n = 0;
    while (status_n === 1'b0 && n < 200) begin
      n++;
      @(posedge pclk);
    end
    chk("pulse", n, 50);
    wr(tsc_pkg::OFF_SRE, 32'h0);
    wr(tsc_pkg::OFF_PULSE, 32'h0);
    rx(tsc_pkg::OFF_STB);
  endtask

  task automatic t_flags();
    logic [7:0] b;
    wr(tsc_pkg::OFF_BIT_INDEX, 32'h1);
    events <= '{8'h06, 8'h06, 8'h06};
    @(posedge pclk);
    events <= '0;
    for (int i = 0; i < 3; i++) begin
      b = tsc_pkg::OFF_ESR + 8'(8 * i);
      rd(b + 8'h4, 32'h1, "flag bit");
      rd(b, 32'h4, "flags");
      rd(b, 32'h0, "flags");
    end
    events <= '{8'hFF, 8'hFF, 8'hFF};
    @(posedge pclk);
    events <= '0;
    wr(tsc_pkg::OFF_COMMAND, 32'h2);
    for (int i = 0; i < 3; i++) rd(tsc_pkg::OFF_ESR + 8'(8 * i), 32'h0, "cleared");
    for (int i = 0; i < 4; i++) begin
      b = tsc_pkg::OFF_SRE + 8'(8 * i);
      wr(b, 32'hA5);
      wr(b + 8'h4, 32'h1);
      rd(b, 32'hA7, "mask");
      rd(b + 8'h4, 32'h1, "mask bit");
      wr(b, 32'h0);
    end
  endtask

  task automatic t_btn_rst();
    for (int i = 0; i < 4; i++) begin
      button_id <= 2'(i);
      button_valid <= 1'b1;
      @(posedge pclk);
      button_valid <= 1'b0;
      rd(tsc_pkg::OFF_BUTTON, 32'(i + 1), "button");
    end
    rd(tsc_pkg::OFF_BUTTON, 32'h0, "button");
    wr(tsc_pkg::OFF_INTERVAL, 32'h14);
    wr(tsc_pkg::OFF_SOURCE, 32'h2);
    strobes = 0;
    wr(tsc_pkg::OFF_COMMAND, 32'h4);
    rd(tsc_pkg::OFF_SOURCE, 32'h0, "source");
    rd(tsc_pkg::OFF_INTERVAL, 32'h3E8, "interval");
    idle();
    chk("strobes", strobes, 1);
  endtask

  task automatic results();
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_cfg();
    t_trigger_flag_bit();
    t_rem();
    t_remote();
    t_stat();
    t_flags();
    t_btn_rst();
    results();
  end
endmodule
